// File: verilog/dic_top.sv
// digital input conditioning: 8 terminal inputs and 16 virtual inputs,
// polarity, delay and function decode, avalon-mm register slave
// assumes virtual inputs come from logic on clk_i and that the
// protection engine consumes the decoded action outputs
`timescale 1ns/1ps
module dic_top
  import dic_pkg::*;
#(
  parameter int DLY_UNIT_CYCLES = DLY_UNIT_CYC
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // avalon-mm slave
  input  wire logic [9:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // terminal and virtual inputs
  input  wire logic [N_PHYS-1:0] input_terminal_block_i,
  input  wire logic [N_VIRT-1:0] virt_in_i,
  // decoded actions
  output logic                   alarm_reset_o,
  output logic                   prot_override_o,
  output logic      [3:0]        cfg_select_o,
  output logic                   aux_current_dis_o,
  output logic                   analog_prot_dis_o,
  output logic      [7:0]        group_dis_o,
  output logic                   generator_breaker_closed_o,
  output logic                   prot_disabled_o,
  output logic                   op_status_o,
  output logic      [5:0]        status_text_o,
  output logic      [N_IN-1:0]   status_inputs_o,
  output logic                   warning_o,
  output logic      [7:0]        warning_msg_o,
  output logic                   shutdown_o,
  output logic      [7:0]        shutdown_msg_o
);

  // ****************************************************************
  // configuration and bus state
  // ****************************************************************
  logic [7:0]        pol_r;
  logic [7:0]        pol_nxt;
  logic [15:0]       func_r [N_IN];
  logic [15:0]       func_nxt [N_IN];
  logic [15:0]       dly_r [N_IN];
  logic [15:0]       dly_nxt [N_IN];
  logic [7:0]        msg_r [N_IN];
  logic [7:0]        msg_nxt [N_IN];
  logic              ack_r;
  logic              ack_nxt;
  logic [31:0]       rd_r;
  logic [31:0]       rd_nxt;

  logic [N_PHYS-1:0] raw_sync;
  logic [N_IN-1:0]   logic_in;
  logic [N_IN-1:0]   dly_q;
  logic [N_IN-1:0]   use_dly;
  logic              req;
  logic              cfg_hit;
  logic [9:0]        cfg_off;
  logic [IDX_W-1:0]  cfg_idx;
  logic [31:0]       act_word;
  logic [31:0]       wmask;
  logic [31:0]       cur_word;

  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_r;
  assign avs_readdata_o    = rd_r;
  assign cfg_hit = (avs_address_i >= REG_CFG_BASE) &&
                   (avs_address_i < REG_CFG_END) &&
                   (avs_address_i[3:2] != 2'h3);
  assign cfg_off = avs_address_i - REG_CFG_BASE;
  assign cfg_idx = cfg_off[IDX_W+3:4];
  assign wmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // ****************************************************************
  // input path
  // ****************************************************************
  dic_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (input_terminal_block_i),
    .sync_o  (raw_sync)
  );

  // low pin = grounded = active unless the polarity bit is set
  assign logic_in = {virt_in_i, ~raw_sync ^ pol_r};

  // delay unit prescaler shared by all timers
  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic        tick;

  assign tick = (pre_r == 32'(DLY_UNIT_CYCLES - 1));

  always_comb begin
    pre_nxt = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign use_dly[gi] = (func_r[gi] == FC_BREAKER) ||
                           (func_r[gi] == FC_WARNING) ||
                           (func_r[gi] == FC_SHUTDOWN);
      dic_delay u_dly (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (tick),
        .act_i     (logic_in[gi]),
        .use_dly_i (use_dly[gi]),
        .dly_i     (dly_r[gi]),
        .q_o       (dly_q[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // function decode
  // ****************************************************************
  logic [N_IN-1:0] prev_r;
  logic [N_IN-1:0] prev_nxt;
  logic            a_reset_nxt;
  logic            a_ovr_nxt;
  logic [3:0]      a_cfg_nxt;
  logic            a_aux_nxt;
  logic            a_ana_nxt;
  logic [7:0]      a_grp_nxt;
  logic            a_brk_nxt;
  logic            a_brk_cfg;
  logic            a_all_dis;
  logic            a_any_dis;
  logic            a_pdis_nxt;
  logic            a_op_nxt;
  logic [5:0]      a_txt_nxt;
  logic [N_IN-1:0] a_sin_nxt;
  logic            a_warn_nxt;
  logic [7:0]      a_wmsg_nxt;
  logic            a_shut_nxt;
  logic [7:0]      a_smsg_nxt;

  always_comb begin
    prev_nxt    = logic_in;
    a_reset_nxt = 1'b0;
    a_ovr_nxt   = 1'b0;
    a_cfg_nxt   = 4'h0;
    a_aux_nxt   = 1'b0;
    a_ana_nxt   = 1'b0;
    a_grp_nxt   = 8'h00;
    a_brk_nxt   = 1'b0;
    a_brk_cfg   = 1'b0;
    a_all_dis   = 1'b1;
    a_any_dis   = 1'b0;
    a_op_nxt    = 1'b0;
    a_txt_nxt   = 6'h00;
    a_sin_nxt   = '0;
    a_warn_nxt  = 1'b0;
    a_wmsg_nxt  = MSG_RST;
    a_shut_nxt  = 1'b0;
    a_smsg_nxt  = MSG_RST;
    // highest index first so the lowest active input owns the message
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (func_r[i] == FC_ALARM_RESET && logic_in[i] && !prev_r[i]) begin
        a_reset_nxt = 1'b1;
      end
      if (func_r[i] == FC_OVERRIDE && logic_in[i]) begin
        a_ovr_nxt = 1'b1;
      end
      if (func_r[i] >= FC_CFG_SEL1 && func_r[i] <= FC_CFG_SEL4 &&
          logic_in[i] && !prev_r[i]) begin
        a_cfg_nxt[2'(func_r[i] - FC_CFG_SEL1)] = 1'b1;
      end
      if (func_r[i] == FC_AUX_CUR_DIS && logic_in[i]) begin
        a_aux_nxt = 1'b1;
      end
      if (func_r[i] == FC_ANALOG_DIS && logic_in[i]) begin
        a_ana_nxt = 1'b1;
      end
      if (func_r[i] >= FC_GRP_DIS1 && func_r[i] <= FC_GRP_DIS8) begin
        a_any_dis = 1'b1;
        if (logic_in[i]) begin
          a_grp_nxt[3'(func_r[i] - FC_GRP_DIS1)] = 1'b1;
        end else begin
          a_all_dis = 1'b0;
        end
      end
      if (func_r[i] == FC_BREAKER) begin
        a_brk_cfg = 1'b1;
        if (dly_q[i]) begin
          a_brk_nxt = 1'b1;
        end
      end
      if (func_r[i] >= FC_3XXX_LO && func_r[i] < FC_4XXX_LO &&
          dly_q[i]) begin
        a_op_nxt = 1'b1;
      end
      if (func_r[i] >= FC_STATUS1 && func_r[i] <= FC_STATUS6 &&
          logic_in[i]) begin
        a_txt_nxt[3'(func_r[i] - FC_STATUS1)] = 1'b1;
        a_sin_nxt[i] = 1'b1;
      end
      if (func_r[i] == FC_WARNING && dly_q[i]) begin
        a_warn_nxt = 1'b1;
        a_wmsg_nxt = msg_r[i];
      end
      if (func_r[i] == FC_SHUTDOWN && dly_q[i]) begin
        a_shut_nxt = 1'b1;
        a_smsg_nxt = msg_r[i];
      end
    end
    a_pdis_nxt = (a_brk_cfg && !a_brk_nxt) ||
                 (a_any_dis && a_all_dis);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_r                     <= '1;
      alarm_reset_o              <= 1'b0;
      prot_override_o            <= 1'b0;
      cfg_select_o               <= 4'h0;
      aux_current_dis_o          <= 1'b0;
      analog_prot_dis_o          <= 1'b0;
      group_dis_o                <= 8'h00;
      generator_breaker_closed_o <= 1'b0;
      prot_disabled_o            <= 1'b0;
      op_status_o                <= 1'b0;
      status_text_o              <= 6'h00;
      status_inputs_o            <= '0;
      warning_o                  <= 1'b0;
      warning_msg_o              <= MSG_RST;
      shutdown_o                 <= 1'b0;
      shutdown_msg_o             <= MSG_RST;
      pre_r                      <= 32'h0000_0000;
    end else begin
      prev_r                     <= prev_nxt;
      alarm_reset_o              <= a_reset_nxt;
      prot_override_o            <= a_ovr_nxt;
      cfg_select_o               <= a_cfg_nxt;
      aux_current_dis_o          <= a_aux_nxt;
      analog_prot_dis_o          <= a_ana_nxt;
      group_dis_o                <= a_grp_nxt;
      generator_breaker_closed_o <= a_brk_nxt;
      prot_disabled_o            <= a_pdis_nxt;
      op_status_o                <= a_op_nxt;
      status_text_o              <= a_txt_nxt;
      status_inputs_o            <= a_sin_nxt;
      warning_o                  <= a_warn_nxt;
      warning_msg_o              <= a_wmsg_nxt;
      shutdown_o                 <= a_shut_nxt;
      shutdown_msg_o             <= a_smsg_nxt;
      pre_r                      <= pre_nxt;
    end
  end

  // ****************************************************************
  // register slave
  // ****************************************************************
  assign act_word = {16'h0000, group_dis_o, op_status_o, prot_disabled_o,
                     shutdown_o, warning_o, generator_breaker_closed_o,
                     analog_prot_dis_o, aux_current_dis_o, prot_override_o};

  always_comb begin
    cur_word = 32'h0000_0000;
    if (cfg_hit) begin
      unique case (avs_address_i[3:2])
        FLD_FUNC: cur_word = {16'h0000, func_r[cfg_idx]};
        FLD_DLY:  cur_word = {16'h0000, dly_r[cfg_idx]};
        FLD_MSG:  cur_word = {24'h00_0000, msg_r[cfg_idx]};
        default:  cur_word = 32'h0000_0000;
      endcase
    end
  end

  // one wait cycle: request seen, read data registered, then released
  always_comb begin
    ack_nxt  = req && !ack_r;
    rd_nxt   = rd_r;
    pol_nxt  = pol_r;
    func_nxt = func_r;
    dly_nxt  = dly_r;
    msg_nxt  = msg_r;
    if (avs_read_i && !ack_r) begin
      if (cfg_hit) begin
        rd_nxt = cur_word;
      end else begin
        unique case (avs_address_i)
          REG_POL:   rd_nxt = {24'h00_0000, pol_r};
          REG_RAW:   rd_nxt = {24'h00_0000, raw_sync};
          REG_LOGIC: rd_nxt = {8'h00, logic_in};
          REG_ACT:   rd_nxt = act_word;
          default:   rd_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (avs_write_i && ack_r) begin
      if (avs_address_i == REG_POL && avs_byteenable_i[0]) begin
        pol_nxt = avs_writedata_i[7:0];
      end
      if (cfg_hit) begin
        unique case (avs_address_i[3:2])
          FLD_FUNC: func_nxt[cfg_idx] = 16'((cur_word & ~wmask) |
                                        (avs_writedata_i & wmask));
          FLD_DLY:  dly_nxt[cfg_idx]  = 16'((cur_word & ~wmask) |
                                        (avs_writedata_i & wmask));
          FLD_MSG:  msg_nxt[cfg_idx]  = 8'((cur_word & ~wmask) |
                                       (avs_writedata_i & wmask));
          default:  pol_nxt = pol_r;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
      pol_r <= POL_RST;
      for (int i = 0; i < N_IN; i++) begin
        func_r[i] <= FC_UNUSED;
        dly_r[i]  <= DLY_RST;
        msg_r[i]  <= MSG_RST;
      end
    end else begin
      ack_r    <= ack_nxt;
      rd_r     <= rd_nxt;
      pol_r    <= pol_nxt;
      func_r   <= func_nxt;
      dly_r    <= dly_nxt;
      msg_r    <= msg_nxt;
    end
  end

endmodule

// File: verilog/dic_pkg.sv
// constants shared by the digital input conditioning block
// assumes one 25 MHz controller clock and an avalon-mm register bus
package dic_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int N_PHYS = 8;
  localparam int N_VIRT = 16;
  localparam int N_IN   = 24;
  localparam int IDX_W  = 5;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ       = 25_000_000;
  localparam int DLY_UNIT_MS  = 1;
  localparam int DLY_UNIT_CYC = DLY_UNIT_MS * CLK_HZ / 1000;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [9:0] REG_POL      = 10'h000;
  localparam logic [9:0] REG_RAW      = 10'h004;
  localparam logic [9:0] REG_LOGIC    = 10'h008;
  localparam logic [9:0] REG_ACT      = 10'h00c;
  localparam logic [9:0] REG_CFG_BASE = 10'h100;
  localparam logic [9:0] REG_CFG_END  = 10'h280;
  localparam logic [1:0] FLD_FUNC     = 2'h0;
  localparam logic [1:0] FLD_DLY      = 2'h1;
  localparam logic [1:0] FLD_MSG      = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  POL_RST = 8'h00;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [7:0]  MSG_RST = 8'h00;

  // ****************************************************************
  // input function codes
  // ****************************************************************
  localparam logic [15:0] FC_UNUSED      = 16'h0000;
  localparam logic [15:0] FC_ALARM_RESET = 16'h07d1;
  localparam logic [15:0] FC_OVERRIDE    = 16'h080f;
  localparam logic [15:0] FC_CFG_SEL1    = 16'h0867;
  localparam logic [15:0] FC_CFG_SEL4    = 16'h086a;
  localparam logic [15:0] FC_AUX_CUR_DIS = 16'h0a90;
  localparam logic [15:0] FC_ANALOG_DIS  = 16'h0a91;
  localparam logic [15:0] FC_GRP_DIS1    = 16'h0a97;
  localparam logic [15:0] FC_GRP_DIS8    = 16'h0a9e;
  localparam logic [15:0] FC_BREAKER     = 16'h0bb9;
  localparam logic [15:0] FC_STATUS1     = 16'h0c81;
  localparam logic [15:0] FC_STATUS6     = 16'h0c86;
  localparam logic [15:0] FC_WARNING     = 16'h0fa1;
  localparam logic [15:0] FC_SHUTDOWN    = 16'h0fa4;
  localparam logic [15:0] FC_3XXX_LO     = 16'h0bb8;
  localparam logic [15:0] FC_4XXX_LO     = 16'h0fa0;
  localparam logic [15:0] FC_5XXX_LO     = 16'h1388;

  // ****************************************************************
  // summary register bit positions
  // ****************************************************************
  localparam int ACT_OVERRIDE = 0;
  localparam int ACT_AUX_DIS  = 1;
  localparam int ACT_ANA_DIS  = 2;
  localparam int ACT_BREAKER  = 3;
  localparam int ACT_WARN     = 4;
  localparam int ACT_SHUT     = 5;
  localparam int ACT_PROT_DIS = 6;
  localparam int ACT_OPSTAT   = 7;
  localparam int ACT_GRP_LSB  = 8;

endpackage

// File: verilog/dic_sync.sv
// two flip-flop synchroniser for the physical terminal inputs
// assumes asynchronous pin levels; resets to the floating level
`timescale 1ns/1ps
module dic_sync
  import dic_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // pins and synchronised levels
  input  wire logic [N_PHYS-1:0] pin_i,
  output logic      [N_PHYS-1:0] sync_o
);

  logic [N_PHYS-1:0] meta_r;
  logic [N_PHYS-1:0] meta_nxt;
  logic [N_PHYS-1:0] sync_r;
  logic [N_PHYS-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
  end

  // reset to all ones: a floating terminal reads high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= {N_PHYS{1'b1}};
      sync_r <= {N_PHYS{1'b1}};
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule

// File: verilog/dic_delay.sv
// per-input activation delay timer
// assumes tick_i is a one-cycle pulse per delay unit on the same clock
`timescale 1ns/1ps
module dic_delay
  import dic_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        tick_i,
  input  wire logic        act_i,
  input  wire logic        use_dly_i,
  input  wire logic [15:0] dly_i,
  // delayed level
  output logic             q_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!act_i) begin
      cnt_nxt = DLY_RST;
    end else if (tick_i && (cnt_r < dly_i)) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= DLY_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // the first unit may be short by up to one tick period
  assign q_o = act_i && (!use_dly_i || (cnt_r >= dly_i));

endmodule

// File: dv/dic_contacts.sv
// dry contacts wired to the eight terminals
// assumes terminals pull up to battery when the contact is open
`timescale 1ns/1ps
module dic_contacts (
  // contact state, bit high = contact closed to ground
  input  wire logic [7:0] closed_i,
  // terminal levels
  output logic      [7:0] pin_o
);
  // open contact floats up to battery, closed one ties to ground
  assign pin_o = ~closed_i;
endmodule

// File: dv/dic_top_props.sv
// port assertions for the input conditioning block
// assumes one clock domain and bind onto dic_top
`timescale 1ns/1ps
module dic_top_props
  import dic_pkg::*;
(
  // clock and reset
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  // bus handshake
  input wire logic            avs_read_i,
  input wire logic            avs_write_i,
  input wire logic            avs_waitrequest_o,
  // decoded actions
  input wire logic            alarm_reset_o,
  input wire logic [3:0]      cfg_select_o,
  input wire logic            generator_breaker_closed_o,
  input wire logic            op_status_o,
  input wire logic [5:0]      status_text_o,
  input wire logic [N_IN-1:0] status_inputs_o,
  input wire logic            warning_o,
  input wire logic [7:0]      warning_msg_o,
  input wire logic            shutdown_o,
  input wire logic [7:0]      shutdown_msg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wait;
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1
      !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_ar;
    alarm_reset_o |=> !alarm_reset_o;
  endproperty
  a_ar: assert property (p_ar) else $error("reset pulse long");
  property p_cfg;
    |cfg_select_o |-> $onehot(cfg_select_o) ##1 cfg_select_o == 4'h0;
  endproperty
  a_cfg: assert property (p_cfg) else $error("select pulse bad");
  property p_wmsg;
    !warning_o |-> warning_msg_o == 8'h00;
  endproperty
  a_wmsg: assert property (p_wmsg) else $error("stray warn msg");
  property p_smsg;
    !shutdown_o |-> shutdown_msg_o == 8'h00;
  endproperty
  a_smsg: assert property (p_smsg) else $error("stray shut msg");
  property p_stat;
    (|status_text_o) == (|status_inputs_o);
  endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  property p_op;
    (|status_text_o) || generator_breaker_closed_o |-> op_status_o;
  endproperty
  a_op: assert property (p_op) else $error("op status missing");
  // no edge pulse or warning may come out of reset itself
  property p_rst;
    $rose(rst_n_i) |-> !alarm_reset_o && cfg_select_o == 4'h0 && !warning_o;
  endproperty
  a_rst: assert property (p_rst) else $error("action after reset");
  c_ar: cover property (alarm_reset_o);
  c_warn: cover property (warning_o);
  c_shut: cover property (shutdown_o);
endmodule

bind dic_top dic_top_props u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .alarm_reset_o(alarm_reset_o), .cfg_select_o(cfg_select_o),
  .generator_breaker_closed_o(generator_breaker_closed_o),
  .op_status_o(op_status_o), .status_text_o(status_text_o),
  .status_inputs_o(status_inputs_o), .warning_o(warning_o),
  .warning_msg_o(warning_msg_o), .shutdown_o(shutdown_o),
  .shutdown_msg_o(shutdown_msg_o)
);

// File: dv/tb_digital_input_conditioning.sv
// self-checking bench for the input conditioning block
// assumes a short delay unit of 4 cycles and contacts on the terminals
`timescale 1ns/1ps
module tb_digital_input_conditioning;
  import dic_pkg::*;
  logic        clk, rst_n, rd, wr, wt_o, ar, ovr, aux, ana, brk, pdis, ops;
  logic        warn, shut;
  logic [9:0]  adr;
  logic [31:0] wd, rdat, q, m;
  logic [3:0]  be, cs;
  logic [7:0]  closed, pins, grp, wmsg, smsg;
  logic [15:0] virt, lq;
  logic [5:0]  stxt;
  logic [23:0] sin;
  int          n_fail, tests_run, cyc;

  dic_contacts dic_contacts_inst (.closed_i(closed), .pin_o(pins));
  dic_top #(.DLY_UNIT_CYCLES(4)) dic_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt_o),
    .input_terminal_block_i(pins), .virt_in_i(virt), .alarm_reset_o(ar),
    .prot_override_o(ovr), .cfg_select_o(cs), .aux_current_dis_o(aux),
    .analog_prot_dis_o(ana), .group_dis_o(grp),
    .generator_breaker_closed_o(brk), .prot_disabled_o(pdis),
    .op_status_o(ops), .status_text_o(stxt), .status_inputs_o(sin),
    .warning_o(warn), .warning_msg_o(wmsg), .shutdown_o(shut),
    .shutdown_msg_o(smsg));

  // ****
  // helpers
  // ****
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [7:0] exp_act(input logic [7:0] pol, input logic [7:0] cl);
    return cl ^ pol;
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d,
           input logic [3:0] b);
    adr <= a; wd <= d; be <= b; wr <= w; rd <= !w;
    do @(posedge clk); while (wt_o !== 1'b0);
    q = rdat; rd <= 1'b0; wr <= 1'b0;
    @(posedge clk);
  endtask
  task cfg(input int i, input logic [15:0] f, input logic [15:0] d,
           input logic [7:0] g);
    logic [9:0] a;
    a = REG_CFG_BASE + 10'(16 * i);
    bus(1'b1, a, {16'h0, f}, 4'hf);
    bus(1'b1, a + 10'h4, {16'h0, d}, 4'hf);
    bus(1'b1, a + 10'h8, {24'h0, g}, 4'hf);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, generous against the roughly 600 cycles of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    int n;
    rst_n = 0; rd = 0; wr = 0; adr = 0; wd = 0; be = 0; closed = 0;
    virt = 0; n_fail = 0; tests_run = 0; cyc = 0; lq = 16'h000a;
    wt(20);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_POL, 0, 4'hf);
    chk(q, 32'h0, "polarity reset");
    bus(1'b0, 10'h010, 0, 4'hf);
    chk(q, 32'h0, "unmapped read");
    lq = lfsr(lq);
    bus(1'b1, REG_POL, {24'h0, lq[7:0]}, 4'hf);
    bus(1'b1, REG_POL, 32'hffff, 4'h2);
    bus(1'b0, REG_POL, 0, 4'hf);
    chk(q, {24'h0, lq[7:0]}, "polarity lanes");
    closed <= lq[15:8];
    virt <= lfsr(lq);
    wt(5);
    bus(1'b0, REG_RAW, 0, 4'hf);
    chk(q, {24'h0, ~closed}, "raw pins");
    bus(1'b0, REG_LOGIC, 0, 4'hf);
    chk(q, {8'h0, virt, exp_act(lq[7:0], closed)}, "logic");
    bus(1'b1, REG_POL, 0, 4'hf);
    closed <= 0;
    virt <= 0;
    // override ignores its huge delay setting
    cfg(0, FC_OVERRIDE, 16'hffff, 8'h00);
    closed <= 8'h01;
    wt(5);
    chk(ovr, 1, "override");
    bus(1'b1, REG_POL, 32'h1, 4'hf);
    wt(5);
    chk(ovr, 0, "inverted grounded");
    closed <= 0;
    wt(5);
    chk(ovr, 1, "inverted floating");
    bus(1'b1, REG_POL, 0, 4'hf);
    cfg(0, FC_UNUSED, 0, 0);
    cfg(1, FC_ALARM_RESET, 0, 0);
    closed <= 8'h02;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      if (ar === 1'b1) n++;
    end
    chk(n, 1, "alarm reset pulses");
    closed <= 0;
    cfg(1, FC_UNUSED, 0, 0);
    for (int k = 0; k < 4; k++) begin
      cfg(8, FC_CFG_SEL1 + 16'(k), 0, 0);
      virt <= 16'h0001;
      n = 0;
      m = 0;
      repeat (8) begin
        @(posedge clk);
        if (cs !== 4'h0) begin
          n++;
          m = {28'h0, cs};
        end
      end
      chk(n, 1, "select count");
      chk(m, 32'h1 << k, "select bit");
      virt <= 0;
      wt(3);
    end
    cfg(8, FC_UNUSED, 0, 0);
    for (int k = 0; k < 6; k++) begin
      cfg(9, FC_STATUS1 + 16'(k), 0, 0);
      virt <= 16'h0002;
      wt(4);
      chk(stxt, 32'h1 << k, "status text");
      chk(sin, 32'h200, "status inputs");
      chk(ops, 1, "op status");
      virt <= 0;
      wt(4);
    end
    cfg(9, FC_UNUSED, 0, 0);
    for (int k = 0; k < 8; k++) begin
      cfg(10, FC_GRP_DIS1 + 16'(k), 0, 0);
      chk(pdis, 0, "group idle");
      virt <= 16'h0004;
      wt(4);
      chk(grp, 32'h1 << k, "group disable");
      chk(pdis, 1, "all groups on");
      virt <= 0;
      wt(4);
    end
    cfg(10, FC_UNUSED, 0, 0);
    cfg(11, FC_AUX_CUR_DIS, 0, 0);
    virt <= 16'h0008;
    wt(4);
    chk(aux, 1, "aux disable");
    cfg(11, FC_ANALOG_DIS, 0, 0);
    chk({aux, ana}, 2'b01, "analog disable");
    virt <= 0;
    cfg(11, FC_UNUSED, 0, 0);
    cfg(12, FC_BREAKER, 0, 0);
    chk(pdis, 1, "breaker open");
    virt <= 16'h0010;
    wt(4);
    chk({brk, pdis}, 2'b10, "breaker closed");
    virt <= 0;
    cfg(12, FC_UNUSED, 0, 0);
    // a dropout mid-delay must restart the count from zero
    lq = lfsr(lq);
    cfg(13, FC_WARNING, 16'h0003, lq[7:0]);
    virt <= 16'h0020;
    wt(6);
    virt <= 0;
    @(posedge clk);
    virt <= 16'h0020;
    wt(6);
    chk(warn, 0, "delay restart");
    wt(10);
    chk(warn, 1, "warning");
    chk(wmsg, lq[7:0], "warning msg");
    virt <= 0;
    cfg(13, FC_UNUSED, 0, 0);
    cfg(14, FC_SHUTDOWN, 0, 8'h5a);
    virt <= 16'h0040;
    wt(4);
    chk({shut, smsg}, {1'b1, 8'h5a}, "shutdown");
    bus(1'b0, REG_ACT, 0, 4'hf);
    chk(q, 32'h1 << ACT_SHUT, "summary");
    bus(1'b0, REG_CFG_BASE + 10'h0e8, 0, 4'hf);
    chk(q, 32'h5a, "message readback");
    // only byte lane one may land; bits above the field are dropped
    bus(1'b1, REG_CFG_BASE + 10'h0e4, 32'hffff_34ff, 4'h2);
    bus(1'b0, REG_CFG_BASE + 10'h0e4, 0, 4'hf);
    chk(q, 32'h3400, "delay lane merge");
    print_verdict;
  end
endmodule
